// ---- src/clock_routing_pkg.sv ----
// shared constants, register map and carrier types for the clock output routing block
package clock_routing_pkg;

  // configuration slots
  localparam int NUM_SLOTS = 6;
  typedef logic [2:0] slot_t;
  typedef logic [7:0] byte_t;
  localparam slot_t SLOT_ZERO = 3'h0;
  localparam slot_t SLOT_ONE = 3'h1;
  localparam slot_t SLOT_TWO = 3'h2;
  localparam slot_t SLOT_THREE = 3'h3;
  localparam slot_t SLOT_FOUR = 3'h4;
  localparam slot_t SLOT_FIVE = 3'h5;

  // register offsets
  localparam byte_t ADDR_FB_LOW_SLOT3 = 8'h6C;
  localparam byte_t ADDR_FB_LOW_SLOT5 = 8'h6D;
  localparam byte_t ADDR_REF_DIV_SLOT4 = 8'h6E;
  localparam byte_t ADDR_REF_DIV_SLOT5 = 8'h6F;
  localparam byte_t ADDR_REF_DIV_SLOT0 = 8'h70;
  localparam byte_t ADDR_REF_DIV_SLOT1 = 8'h71;
  localparam byte_t ADDR_REF_DIV_SLOT2 = 8'h72;
  localparam byte_t ADDR_REF_DIV_SLOT3 = 8'h73;
  localparam byte_t ADDR_RESERVED_A = 8'h74;
  localparam byte_t ADDR_OUTPUT_ZERO = 8'h75;
  localparam byte_t ADDR_PAIR_A = 8'h76;
  localparam byte_t ADDR_PIN_TWO_SLEW = 8'h77;
  localparam byte_t ADDR_PAIR_B = 8'h78;
  localparam byte_t ADDR_RESERVED_B = 8'h79;
  localparam byte_t ADDR_OUTPUT_FIVE = 8'h7A;
  localparam byte_t ADDR_PIN_SIX_SLEW = 8'h7B;
  localparam byte_t ADDR_RESERVED_C = 8'h7C;

  // field positions shared by the output control registers
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int SLEW_HI = 5;
  localparam int SLEW_LO = 4;
  localparam int INV_HI = 3;
  localparam int INV_LO = 2;
  localparam int INV_ZERO_BIT = 3;
  localparam int ROUTE_A_BIT = 1;
  localparam int ROUTE_B_BIT = 0;

  // reset and fixed read values
  localparam byte_t RST_CLEAR = 8'h00;
  localparam byte_t RST_OUTPUT_ZERO = 8'h03;
  localparam byte_t RESERVED_A_VALUE = 8'h01;
  localparam logic [1:0] RST_FIELD2 = 2'h0;

  // disable mode encoding: low bit clear floats the pin, else upper bit is the parked level
  localparam int MODE_DRIVE_BIT = 0;
  localparam int MODE_LEVEL_BIT = 1;

  // output pin order
  localparam int NUM_PINS = 7;
  localparam int PIN_ZERO = 0;
  localparam int PIN_ONE = 1;
  localparam int PIN_TWO = 2;
  localparam int PIN_THREE = 3;
  localparam int PIN_FIVE = 4;
  localparam int PIN_FIVE_COMP = 5;
  localparam int PIN_SIX = 6;

  // one register port request
  typedef struct packed {
    logic wr;
    byte_t addr;
    byte_t wdata;
  } reg_req_s;

  // per-pin disable and inversion control
  typedef struct packed {
    logic [1:0] disable_mode;
    logic invert;
  } pin_ctrl_s;

  // output divider results feeding the routing
  typedef struct packed {
    logic div0;
    logic first_output_divider;
    logic second_output_divider;
    logic third_output_divider;
    logic div5;
    logic sixth_output_divider;
  } divider_clocks_s;

endpackage

// ---- src/slot_register_bank.sv ----
// six-slot byte store with a write port, an addressed read and a registered active-slot value
`timescale 1ns/1ps
`default_nettype none
module slot_register_bank (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_wr,
  input wire clock_routing_pkg::slot_t i_wr_slot,
  input wire clock_routing_pkg::byte_t i_wdata,
  input wire clock_routing_pkg::slot_t i_rd_slot,
  input wire clock_routing_pkg::slot_t i_active_slot,
  output clock_routing_pkg::byte_t o_rd_data,
  output clock_routing_pkg::byte_t o_active_data
);
  import clock_routing_pkg::*;

  byte_t slot_mem [NUM_SLOTS];

  // per-slot storage, one entry per configuration
  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g = g + 1) begin : g_slot
      always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
          slot_mem[g] <= RST_CLEAR;
        end else if (i_clk_en && i_wr && (i_wr_slot == slot_t'(g))) begin
          slot_mem[g] <= i_wdata;
        end
      end
    end
  endgenerate

  // addressed read for the register port
  assign o_rd_data = slot_mem[i_rd_slot];

  // active copy follows the selection one cycle later
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_active_data <= RST_CLEAR;
    end else if (i_clk_en) begin
      o_active_data <= slot_mem[i_active_slot];
    end
  end

endmodule
`default_nettype wire

// ---- src/pin_drive_stage.sv ----
// one output pin: inversion while enabled, disable mode while disabled
`timescale 1ns/1ps
`default_nettype none
module pin_drive_stage (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_clock,
  input wire logic i_enable,
  input wire clock_routing_pkg::pin_ctrl_s i_ctrl,
  output logic o_level,
  output logic o_oe
);
  import clock_routing_pkg::*;

  // R5: invert select
  // R3: disabled state
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_level <= 1'b0;
      o_oe <= 1'b0;
    end else if (i_clk_en) begin
      if (i_enable) begin
        o_level <= i_clock ^ i_ctrl.invert;
        o_oe <= 1'b1;
      end else if (!i_ctrl.disable_mode[MODE_DRIVE_BIT]) begin
        o_level <= 1'b0; // floated
        o_oe <= 1'b0;
      end else begin
        o_level <= i_ctrl.disable_mode[MODE_LEVEL_BIT]; // parked
        o_oe <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ---- src/clock_output_routing_control.sv ----
// configuration registers, output routing and pin control of the clock generator
//
// Behaviour
// R1: first pair select 1 drives pins one and two from dividers one and two, 0 drives both from divider two.
// R2: second pair select 1 drives pins three and six from dividers three and six, 0 drives both from divider six.
// R3: a disable mode with low bit 0 floats the pin, 01 parks it low and 11 parks it high.
// R4: the disable mode in the first output control register governs pin zero alone.
// R5: each inversion bit passes its clock when 0 and inverts it when 1, one bit per clock of the pair.
// R6: the disable mode of the second output control register governs pins one and two together.
// R7: the disable mode of the fourth output control register governs pins three and six together.
// R8: the disable mode of the sixth output control register governs pin five and its complement together.
// R9: an eight-bit spread reference divide is held per slot and the active slot's value is used.
// R10: the low byte of the spread feedback counter is held for slots three and five only, the high byte living elsewhere.
// R11: every per-slot group applies the copy of the active selection and follows it when it changes.
// R12: edge rate fields are stored and read back with no effect on routing or enables.
`timescale 1ns/1ps
`default_nettype none
module clock_output_routing_control (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire clock_routing_pkg::reg_req_s i_reg_req,
  output clock_routing_pkg::byte_t o_reg_rdata,
  input wire clock_routing_pkg::slot_t i_config_select_pin,
  input wire logic i_output_enable_pin,
  input wire clock_routing_pkg::divider_clocks_s i_dividers,
  output clock_routing_pkg::byte_t o_pll3_spread_ref_div,
  output clock_routing_pkg::byte_t o_pll3_spread_fb_count_low,
  output logic [clock_routing_pkg::NUM_PINS-1:0] o_pin_level,
  output logic [clock_routing_pkg::NUM_PINS-1:0] o_pin_oe
);
  import clock_routing_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  slot_t select_meta;
  slot_t select_sync;
  logic enable_meta;
  logic enable_sync;
  slot_t active_slot;

  // two flops on the selection and enable pins
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      select_meta <= SLOT_ZERO;
      select_sync <= SLOT_ZERO;
      enable_meta <= 1'b0;
      enable_sync <= 1'b0;
    end else if (i_clk_en) begin
      select_meta <= i_config_select_pin;
      select_sync <= select_meta;
      enable_meta <= i_output_enable_pin;
      enable_sync <= enable_meta;
    end
  end

  // R11: active slot
  // selections past the last slot fall back to slot zero
  always_comb begin
    if (select_sync > SLOT_FIVE) begin
      active_slot = SLOT_ZERO;
    end else begin
      active_slot = select_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // per-slot register groups

  logic ref_div_hit;
  slot_t ref_div_slot;
  logic fb_low_hit;
  slot_t fb_low_slot;
  byte_t ref_div_rd;
  byte_t fb_low_rd;

  // map the reference divide offsets to their slots
  always_comb begin
    ref_div_hit = 1'b1;
    if (i_reg_req.addr == ADDR_REF_DIV_SLOT0) begin
      ref_div_slot = SLOT_ZERO;
    end else if (i_reg_req.addr == ADDR_REF_DIV_SLOT1) begin
      ref_div_slot = SLOT_ONE;
    end else if (i_reg_req.addr == ADDR_REF_DIV_SLOT2) begin
      ref_div_slot = SLOT_TWO;
    end else if (i_reg_req.addr == ADDR_REF_DIV_SLOT3) begin
      ref_div_slot = SLOT_THREE;
    end else if (i_reg_req.addr == ADDR_REF_DIV_SLOT4) begin
      ref_div_slot = SLOT_FOUR;
    end else if (i_reg_req.addr == ADDR_REF_DIV_SLOT5) begin
      ref_div_slot = SLOT_FIVE;
    end else begin
      ref_div_slot = SLOT_ZERO;
      ref_div_hit = 1'b0;
    end
  end

  // map the feedback low byte offsets held here to their slots
  always_comb begin
    fb_low_hit = 1'b1;
    if (i_reg_req.addr == ADDR_FB_LOW_SLOT3) begin
      fb_low_slot = SLOT_THREE;
    end else if (i_reg_req.addr == ADDR_FB_LOW_SLOT5) begin
      fb_low_slot = SLOT_FIVE;
    end else begin
      fb_low_slot = SLOT_ZERO;
      fb_low_hit = 1'b0;
    end
  end

  // R9: reference divide per slot
  slot_register_bank u_ref_div_bank (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .i_wr(i_reg_req.wr && ref_div_hit),
    .i_wr_slot(ref_div_slot),
    .i_wdata(i_reg_req.wdata),
    .i_rd_slot(ref_div_slot),
    .i_active_slot(active_slot),
    .o_rd_data(ref_div_rd),
    .o_active_data(o_pll3_spread_ref_div)
  );

  // R10: feedback low byte per slot
  slot_register_bank u_fb_low_bank (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .i_wr(i_reg_req.wr && fb_low_hit),
    .i_wr_slot(fb_low_slot),
    .i_wdata(i_reg_req.wdata),
    .i_rd_slot(fb_low_slot),
    .i_active_slot(active_slot),
    .o_rd_data(fb_low_rd),
    .o_active_data(o_pll3_spread_fb_count_low)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // output control registers

  logic [1:0] pin_zero_disable_mode;
  logic [1:0] pin_zero_edge_rate;
  logic pin_zero_invert;
  logic first_pair_route_select;
  logic second_pair_route_select;
  logic [1:0] pair_a_disable_mode;
  logic [1:0] pair_a_edge_rate;
  logic [1:0] pair_a_invert;
  logic [1:0] pin_two_edge_rate;
  logic [1:0] pair_b_disable_mode;
  logic [1:0] pair_b_edge_rate;
  logic [1:0] pair_b_invert;
  logic [1:0] pin_five_disable_mode;
  logic [1:0] pin_five_edge_rate;
  logic [1:0] pin_five_invert;
  logic [1:0] pin_six_edge_rate;

  // output zero register, routing selects reset to the divider-per-pin setting
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pin_zero_disable_mode <= RST_OUTPUT_ZERO[MODE_HI:MODE_LO];
      pin_zero_edge_rate <= RST_OUTPUT_ZERO[SLEW_HI:SLEW_LO];
      pin_zero_invert <= RST_OUTPUT_ZERO[INV_ZERO_BIT];
      first_pair_route_select <= RST_OUTPUT_ZERO[ROUTE_A_BIT];
      second_pair_route_select <= RST_OUTPUT_ZERO[ROUTE_B_BIT];
    end else if (i_clk_en && i_reg_req.wr && (i_reg_req.addr == ADDR_OUTPUT_ZERO)) begin
      pin_zero_disable_mode <= i_reg_req.wdata[MODE_HI:MODE_LO];
      pin_zero_edge_rate <= i_reg_req.wdata[SLEW_HI:SLEW_LO];
      pin_zero_invert <= i_reg_req.wdata[INV_ZERO_BIT];
      first_pair_route_select <= i_reg_req.wdata[ROUTE_A_BIT];
      second_pair_route_select <= i_reg_req.wdata[ROUTE_B_BIT];
    end
  end

  // pair a register
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pair_a_disable_mode <= RST_FIELD2;
      pair_a_edge_rate <= RST_FIELD2;
      pair_a_invert <= RST_FIELD2;
    end else if (i_clk_en && i_reg_req.wr && (i_reg_req.addr == ADDR_PAIR_A)) begin
      pair_a_disable_mode <= i_reg_req.wdata[MODE_HI:MODE_LO];
      pair_a_edge_rate <= i_reg_req.wdata[SLEW_HI:SLEW_LO];
      pair_a_invert <= i_reg_req.wdata[INV_HI:INV_LO];
    end
  end

  // R12: edge rate storage
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pin_two_edge_rate <= RST_FIELD2;
      pin_six_edge_rate <= RST_FIELD2;
    end else if (i_clk_en && i_reg_req.wr) begin
      if (i_reg_req.addr == ADDR_PIN_TWO_SLEW) begin
        pin_two_edge_rate <= i_reg_req.wdata[MODE_HI:MODE_LO];
      end else if (i_reg_req.addr == ADDR_PIN_SIX_SLEW) begin
        pin_six_edge_rate <= i_reg_req.wdata[SLEW_HI:SLEW_LO];
      end
    end
  end

  // pair b register
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pair_b_disable_mode <= RST_FIELD2;
      pair_b_edge_rate <= RST_FIELD2;
      pair_b_invert <= RST_FIELD2;
    end else if (i_clk_en && i_reg_req.wr && (i_reg_req.addr == ADDR_PAIR_B)) begin
      pair_b_disable_mode <= i_reg_req.wdata[MODE_HI:MODE_LO];
      pair_b_edge_rate <= i_reg_req.wdata[SLEW_HI:SLEW_LO];
      pair_b_invert <= i_reg_req.wdata[INV_HI:INV_LO];
    end
  end

  // pin five register
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pin_five_disable_mode <= RST_FIELD2;
      pin_five_edge_rate <= RST_FIELD2;
      pin_five_invert <= RST_FIELD2;
    end else if (i_clk_en && i_reg_req.wr && (i_reg_req.addr == ADDR_OUTPUT_FIVE)) begin
      pin_five_disable_mode <= i_reg_req.wdata[MODE_HI:MODE_LO];
      pin_five_edge_rate <= i_reg_req.wdata[SLEW_HI:SLEW_LO];
      pin_five_invert <= i_reg_req.wdata[INV_HI:INV_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register read back

  byte_t next_rdata;

  // reserved bits read zero, the first reserved byte reads its fixed value
  always_comb begin
    next_rdata = RST_CLEAR;
    if (ref_div_hit) begin
      next_rdata = ref_div_rd;
    end else if (fb_low_hit) begin
      next_rdata = fb_low_rd;
    end else if (i_reg_req.addr == ADDR_RESERVED_A) begin
      next_rdata = RESERVED_A_VALUE;
    end else if (i_reg_req.addr == ADDR_OUTPUT_ZERO) begin
      next_rdata[MODE_HI:MODE_LO] = pin_zero_disable_mode;
      next_rdata[SLEW_HI:SLEW_LO] = pin_zero_edge_rate;
      next_rdata[INV_ZERO_BIT] = pin_zero_invert;
      next_rdata[ROUTE_A_BIT] = first_pair_route_select;
      next_rdata[ROUTE_B_BIT] = second_pair_route_select;
    end else if (i_reg_req.addr == ADDR_PAIR_A) begin
      next_rdata[MODE_HI:MODE_LO] = pair_a_disable_mode;
      next_rdata[SLEW_HI:SLEW_LO] = pair_a_edge_rate;
      next_rdata[INV_HI:INV_LO] = pair_a_invert;
    end else if (i_reg_req.addr == ADDR_PIN_TWO_SLEW) begin
      next_rdata[MODE_HI:MODE_LO] = pin_two_edge_rate;
    end else if (i_reg_req.addr == ADDR_PAIR_B) begin
      next_rdata[MODE_HI:MODE_LO] = pair_b_disable_mode;
      next_rdata[SLEW_HI:SLEW_LO] = pair_b_edge_rate;
      next_rdata[INV_HI:INV_LO] = pair_b_invert;
    end else if (i_reg_req.addr == ADDR_OUTPUT_FIVE) begin
      next_rdata[MODE_HI:MODE_LO] = pin_five_disable_mode;
      next_rdata[SLEW_HI:SLEW_LO] = pin_five_edge_rate;
      next_rdata[INV_HI:INV_LO] = pin_five_invert;
    end else if (i_reg_req.addr == ADDR_PIN_SIX_SLEW) begin
      next_rdata[SLEW_HI:SLEW_LO] = pin_six_edge_rate;
    end
  end

  // read data registered one cycle after the address
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_reg_rdata <= RST_CLEAR;
    end else if (i_clk_en) begin
      o_reg_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // routing and pin stages

  logic [NUM_PINS-1:0] pin_clock;
  pin_ctrl_s pin_ctrl [NUM_PINS];

  // R1: first pair routing
  // R2: second pair routing
  always_comb begin
    pin_clock[PIN_ZERO] = i_dividers.div0;
    pin_clock[PIN_ONE] = first_pair_route_select ? i_dividers.first_output_divider
                                                 : i_dividers.second_output_divider;
    pin_clock[PIN_TWO] = i_dividers.second_output_divider;
    pin_clock[PIN_THREE] = second_pair_route_select ? i_dividers.third_output_divider
                                                    : i_dividers.sixth_output_divider;
    pin_clock[PIN_SIX] = i_dividers.sixth_output_divider;
    pin_clock[PIN_FIVE] = i_dividers.div5;
    pin_clock[PIN_FIVE_COMP] = ~i_dividers.div5; // complement pin of pin five
  end

  // R4: pin zero own mode
  // R6: pair a shared mode
  // R7: pair b shared mode
  // R8: pin five pair shared mode
  always_comb begin
    pin_ctrl[PIN_ZERO] = '{disable_mode: pin_zero_disable_mode, invert: pin_zero_invert};
    pin_ctrl[PIN_ONE] = '{disable_mode: pair_a_disable_mode, invert: pair_a_invert[0]};
    pin_ctrl[PIN_TWO] = '{disable_mode: pair_a_disable_mode, invert: pair_a_invert[1]};
    pin_ctrl[PIN_THREE] = '{disable_mode: pair_b_disable_mode, invert: pair_b_invert[0]};
    pin_ctrl[PIN_SIX] = '{disable_mode: pair_b_disable_mode, invert: pair_b_invert[1]};
    pin_ctrl[PIN_FIVE] = '{disable_mode: pin_five_disable_mode, invert: pin_five_invert[0]};
    pin_ctrl[PIN_FIVE_COMP] = '{disable_mode: pin_five_disable_mode, invert: pin_five_invert[1]};
  end

  // one registered drive stage per pin
  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p = p + 1) begin : g_pin
      pin_drive_stage u_stage (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_clk_en(i_clk_en),
        .i_clock(pin_clock[p]),
        .i_enable(enable_sync),
        .i_ctrl(pin_ctrl[p]),
        .o_level(o_pin_level[p]),
        .o_oe(o_pin_oe[p])
      );
    end
  endgenerate

endmodule
`default_nettype wire

// ---- bench/clock_routing_assertions.sv ----
// assertion checker for the clock output routing block
`timescale 1ns/1ps
`default_nettype none
module clock_routing_assertions (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire clock_routing_pkg::reg_req_s i_reg_req,
  input wire logic [7:0] o_reg_rdata,
  input wire logic [2:0] i_config_select_pin,
  input wire logic i_output_enable_pin,
  input wire clock_routing_pkg::divider_clocks_s i_dividers,
  input wire logic [7:0] o_pll3_spread_ref_div,
  input wire logic [7:0] o_pll3_spread_fb_count_low,
  input wire logic [6:0] o_pin_level,
  input wire logic [6:0] o_pin_oe
);
  import clock_routing_pkg::*;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  byte_t regs [8'h6C:8'h7B];
  byte_t exp_rd, exp_ref, exp_fb, c0, ca, cb, c5;
  logic [2:0] en_run, dis_run, sel_run;
  logic [6:0] exp_lvl, dis_lvl, dis_oe;
  slot_t sel_q, slot;
  logic go;
  function automatic byte_t wmask(byte_t a);
    case (a)
      8'h74, 8'h79: return 8'h00;
      8'h75: return 8'hFB;
      8'h76, 8'h78, 8'h7A: return 8'hFC;
      8'h77: return 8'hC0;
      8'h7B: return 8'h30;
      default: return 8'hFF;
    endcase
  endfunction
  // saturating run length
  function automatic logic [2:0] bump(logic ok, logic [2:0] c);
    return !ok ? 3'h0 : (c[2] ? c : c + 3'h1);
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // shadow register file
  always_ff @(posedge i_sys_clk) begin
    if (i_rst && i_clk_en) begin
      for (int a = 8'h6C; a <= 8'h7B; a++) begin
        regs[a] <= (a == 8'h74) ? 8'h01 : ((a == 8'h75) ? 8'h03 : 8'h00);
      end
    end else if (i_clk_en && i_reg_req.wr && i_reg_req.addr inside {[8'h6C:8'h7B]}) begin
      regs[i_reg_req.addr] <= (i_reg_req.wdata & wmask(i_reg_req.addr)) | (regs[i_reg_req.addr] & ~wmask(i_reg_req.addr));
    end
  end
  // run lengths of the pins
  always_ff @(posedge i_sys_clk) begin
    en_run <= bump(go && i_output_enable_pin, en_run);
    dis_run <= bump(go && !i_output_enable_pin, dis_run);
    sel_run <= bump(go && i_config_select_pin == sel_q, sel_run);
    sel_q <= i_config_select_pin;
  end
  // expected values
  always_comb begin
    go = i_clk_en && !i_rst;
    c0 = regs[8'h75];
    ca = regs[8'h76];
    cb = regs[8'h78];
    c5 = regs[8'h7A];
    slot = (i_config_select_pin > 3'h5) ? 3'h0 : i_config_select_pin;
    exp_ref = regs[slot[2] ? 8'h6A + {5'h0, slot} : 8'h70 + {5'h0, slot}];
    exp_fb = (slot == 3'h3) ? regs[8'h6C] : ((slot == 3'h5) ? regs[8'h6D] : 8'h00);
    exp_rd = (i_reg_req.addr inside {[8'h6C:8'h7B]}) ? regs[i_reg_req.addr] : 8'h00;
    exp_lvl[0] = i_dividers.div0 ^ c0[3];
    exp_lvl[1] = (c0[1] ? i_dividers.first_output_divider : i_dividers.second_output_divider) ^ ca[2];
    exp_lvl[2] = i_dividers.second_output_divider ^ ca[3];
    exp_lvl[3] = (c0[0] ? i_dividers.third_output_divider : i_dividers.sixth_output_divider) ^ cb[2];
    exp_lvl[4] = i_dividers.div5 ^ c5[2];
    exp_lvl[5] = ~i_dividers.div5 ^ c5[3];
    exp_lvl[6] = i_dividers.sixth_output_divider ^ cb[3];
    dis_oe = {cb[6], c5[6], c5[6], cb[6], ca[6], ca[6], c0[6]};
    dis_lvl = dis_oe & {cb[7], c5[7], c5[7], cb[7], ca[7], ca[7], c0[7]};
  end
  ////////////////////////////////////////////////////////////////////////////////
  reset_clear_a:
    assert property (disable iff (1'b0) i_rst && i_clk_en |=> o_pin_oe == 7'h00 && o_pin_level == 7'h00
      && o_reg_rdata == 8'h00 && o_pll3_spread_ref_div == 8'h00 && o_pll3_spread_fb_count_low == 8'h00)
    else $error("reset outputs");
  read_back_a:
    assert property (go && !i_reg_req.wr |=> o_reg_rdata == $past(exp_rd))
    else $error("read data");
  route_first_a:
    assert property (en_run >= 3'h3 |-> o_pin_level[2:1] == $past(exp_lvl[2:1]))
    else $error("pair one route");
  route_second_a:
    assert property (en_run >= 3'h3 |-> {o_pin_level[6], o_pin_level[3]} == {$past(exp_lvl[6]), $past(exp_lvl[3])})
    else $error("pair two route");
  invert_single_a:
    assert property (en_run >= 3'h3 |-> {o_pin_level[5:4], o_pin_level[0]} == {$past(exp_lvl[5:4]), $past(exp_lvl[0])})
    else $error("inversion");
  drive_enabled_a:
    assert property (en_run >= 3'h3 |-> o_pin_oe == 7'h7F)
    else $error("enabled drive");
  disabled_level_a:
    assert property (dis_run >= 3'h3 |-> o_pin_level == $past(dis_lvl))
    else $error("disabled level");
  disabled_oe_a:
    assert property (dis_run >= 3'h3 |-> o_pin_oe == $past(dis_oe))
    else $error("disabled drive");
  spread_select_a:
    assert property (sel_run >= 3'h3 |-> o_pll3_spread_ref_div == $past(exp_ref)
      && o_pll3_spread_fb_count_low == $past(exp_fb))
    else $error("spread slot");
endmodule
bind clock_output_routing_control clock_routing_assertions clock_routing_assertions_i (
  .i_sys_clk, .i_rst, .i_clk_en, .i_reg_req, .o_reg_rdata, .i_config_select_pin, .i_output_enable_pin,
  .i_dividers, .o_pll3_spread_ref_div, .o_pll3_spread_fb_count_low, .o_pin_level, .o_pin_oe
);
`default_nettype wire

// ---- bench/reg_host_model.sv ----
// register port host model
`timescale 1ns/1ps
`default_nettype none
module reg_host_model (
  input wire logic i_sys_clk,
  input wire clock_routing_pkg::byte_t i_rdata,
  output clock_routing_pkg::reg_req_s o_req
);
  import clock_routing_pkg::*;
  initial o_req = '0;
  // write strobe for one edge
  task automatic write_byte(input byte_t addr, input byte_t data);
    @(negedge i_sys_clk);
    o_req <= '{wr: 1'b1, addr: addr, wdata: data};
    @(negedge i_sys_clk);
    o_req <= '{wr: 1'b0, addr: ~addr, wdata: ~data};
  endtask
  // read, data one cycle later
  task automatic read_byte(input byte_t addr, output byte_t data);
    @(negedge i_sys_clk);
    o_req <= '{wr: 1'b0, addr: addr, wdata: ~addr};
    @(negedge i_sys_clk);
    data = i_rdata;
  endtask
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// self-checking bench for the clock output routing block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import clock_routing_pkg::*;
  logic i_sys_clk, i_rst, i_clk_en, i_output_enable_pin;
  slot_t i_config_select_pin;
  logic [5:0] div_cnt;
  reg_req_s req;
  byte_t rdata, ref_div, fb_low, rd;
  logic [6:0] lvl, oe;
  int fail_count, comparisons;
  clock_output_routing_control clock_output_routing_control_i (
    .i_sys_clk, .i_rst, .i_clk_en, .i_reg_req(req), .o_reg_rdata(rdata),
    .i_config_select_pin, .i_output_enable_pin,
    .i_dividers(divider_clocks_s'(div_cnt)), .o_pll3_spread_ref_div(ref_div),
    .o_pll3_spread_fb_count_low(fb_low), .o_pin_level(lvl), .o_pin_oe(oe)
  );
  reg_host_model reg_host_model_i (.i_sys_clk, .i_rdata(rdata), .o_req(req));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  // divider clocks count
  always @(negedge i_sys_clk) div_cnt <= div_cnt + 6'h01;
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  function automatic byte_t rmask(byte_t a);
    case (a)
      8'h74: return 8'h01;
      8'h75: return 8'hFB;
      8'h76, 8'h78, 8'h7A: return 8'hFC;
      8'h77: return 8'hC0;
      8'h7B: return 8'h30;
      default: return (a inside {[8'h6C:8'h73]}) ? 8'hFF : 8'h00;
    endcase
  endfunction
  task automatic wr(input byte_t a, input byte_t d);
    reg_host_model_i.write_byte(a, d);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // reset values and write masks
  task automatic regs_access();
    for (int a = 8'h6A; a <= 8'h7D; a++) begin
      reg_host_model_i.read_byte(8'(a), rd);
      check("reset", rd, (a == 8'h74) ? 8'h01 : ((a == 8'h75) ? 8'h03 : 8'h00));
      wr(8'(a), 8'hFF);
      reg_host_model_i.read_byte(8'(a), rd);
      check("read back", rd, rmask(8'(a)));
      wr(8'(a), 8'h00);
    end
  endtask
  // enable latency, routes and inversion
  task automatic routing();
    byte_t c0, cx;
    logic [5:0] d;
    i_output_enable_pin = 1'b1;
    repeat (2) @(negedge i_sys_clk) check("oe early", oe, 8'h00);
    @(negedge i_sys_clk) check("oe late", oe, 8'h7F);
    for (int k = 0; k < 16; k++) begin
      c0 = {4'h0, k[0], 1'b0, k[3], k[2]};
      cx = {4'h0, k[1:0], 2'h0};
      wr(8'h75, c0);
      wr(8'h76, cx);
      wr(8'h78, cx);
      wr(8'h7A, cx);
      repeat (4) begin
        @(negedge i_sys_clk);
        d = div_cnt;
        check("routed", lvl, {d[0] ^ cx[3], ~d[1] ^ cx[3], d[1] ^ cx[2], (c0[0] ? d[2] : d[0]) ^ cx[2],
          d[3] ^ cx[3], (c0[1] ? d[4] : d[3]) ^ cx[2], d[5] ^ c0[3]});
      end
    end
  endtask
  // disable modes
  task automatic disabled();
    logic [1:0] m0, ma, mb, m5;
    i_output_enable_pin = 1'b0;
    for (int m = 0; m < 4; m++) begin
      m0 = 2'(m);
      ma = 2'(m + 1);
      mb = 2'(m + 2);
      m5 = 2'(m + 3);
      wr(8'h75, {m0, 6'h0});
      wr(8'h76, {ma, 6'h0});
      wr(8'h78, {mb, 6'h0});
      wr(8'h7A, {m5, 6'h0});
      repeat (2) @(negedge i_sys_clk);
      check("dis oe", oe, {mb[0], m5[0], m5[0], mb[0], ma[0], ma[0], m0[0]});
      check("dis level", lvl, {mb[0] & mb[1], m5[0] & m5[1], m5[0] & m5[1], mb[0] & mb[1],
        ma[0] & ma[1], ma[0] & ma[1], m0[0] & m0[1]});
    end
  endtask
  // per-slot values by selection
  task automatic selection();
    slot_t s;
    for (int a = 8'h6C; a <= 8'h73; a++) wr(8'(a), 8'(a) ^ 8'h5A);
    for (int k = 7; k >= 0; k--) begin
      s = (k > 5) ? 3'h0 : 3'(k);
      @(negedge i_sys_clk) i_config_select_pin = 3'(k);
      repeat (3) @(negedge i_sys_clk);
      check("ref divide", ref_div, (s[2] ? 8'h6A + 8'(s) : 8'h70 + 8'(s)) ^ 8'h5A);
      check("fb low", fb_low, (s == 3'h3) ? 8'h36 : ((s == 3'h5) ? 8'h37 : 8'h00));
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    fail_count = 0;
    comparisons = 0;
    i_rst = 1'b1;
    i_clk_en = 1'b1;
    i_output_enable_pin = 1'b0;
    i_config_select_pin = 3'h0;
    div_cnt = 6'h00;
    repeat (4) @(negedge i_sys_clk);
    i_rst = 1'b0;
    regs_access();
    routing();
    disabled();
    selection();
    @(negedge i_sys_clk) i_rst = 1'b1;
    @(negedge i_sys_clk) i_rst = 1'b0;
    check("reset oe", oe, 8'h00);
    reg_host_model_i.read_byte(8'h75, rd);
    check("reset again", rd, 8'h03);
    close_out();
  end
  initial begin
    #(20000 * 4);
    fail_count++;
    close_out();
  end
endmodule
`default_nettype wire
